/* File: host_lane_strap.sv */
`timescale 1ns/1ps
`default_nettype none

module host_lane_strap (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bus32_option_i,
    input wire lane_cfg_pkg::strap_t strap_i,
    input wire lane_cfg_pkg::host_req_t req_i,
    input wire logic [lane_cfg_pkg::DATA_W-1:0] data_in_i,
    input wire logic [lane_cfg_pkg::DATA_W-1:0] core_rdata_i,
    input wire logic rx_pointer_big_end_i,
    output logic [lane_cfg_pkg::DATA_W-1:0] data_out_o,
    output logic [lane_cfg_pkg::DATA_W-1:0] data_oe_n_o,
    output logic [lane_cfg_pkg::DATA_W-1:0] core_wdata_o,
    output logic [lane_cfg_pkg::LANES-1:0] core_lane_we_o,
    output logic [lane_cfg_pkg::CFG_W-1:0] chip_config_reg_o,
    output logic big_endian_o,
    output logic [1:0] bus_width_o
);
    import lane_cfg_pkg::*;

    // ==========================================================
    // Strap capture.
    // ==========================================================
    logic endian_lvl;
    logic width_lvl;
    logic eeprom_lvl;
    logic [CFG_W-1:0] cfg_reg;
    logic [CFG_W-1:0] cfg_next;

    // Capture sequence: one edge for the synchronisers to hand over the levels
    // they held through reset, one edge to take them, then frozen.
    typedef enum {
        cap_wait,
        cap_take,
        cap_done
    } cap_state_t;
    cap_state_t cap_state_reg;
    cap_state_t cap_state_next;

    // Straps are pins from outside the clock domain, so each is synchronised.
    pin_sync u_sync_endian (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(strap_i.endian_select_strap),
        .level_o(endian_lvl)
    );
    pin_sync u_sync_width (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(strap_i.bus_width_strap),
        .level_o(width_lvl)
    );
    pin_sync u_sync_eeprom (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(strap_i.eeprom_present_strap),
        .level_o(eeprom_lvl)
    );

    // The synchronisers keep running while rst_i is high, so at release they hold
    // the strap levels seen during reset. Only those levels are taken: a strap
    // that moves at or after release never reaches the register.
    // The price is one extra edge after release before the config is valid,
    // which is harmless because nothing reads the straps before that.
    always_comb begin
        cfg_next = cfg_reg;
        cap_state_next = cap_state_reg;
        case (cap_state_reg)
            cap_wait: begin
                // The synchronised levels become valid at this edge.
                cap_state_next = cap_take;
            end
            cap_take: begin
                cfg_next[CFG_BIG_END_BIT] = endian_lvl;
                // In 32-bit mode, or with an EEPROM fitted, the width strap is ignored.
                if (!bus32_option_i && !eeprom_lvl) begin
                    cfg_next[CFG_BUS16_BIT] = width_lvl;
                    cfg_next[CFG_BUS8_BIT] = ~width_lvl;
                end
                cap_state_next = cap_done;
            end
            cap_done: begin
                // Frozen until the next reset.
                cap_state_next = cap_done;
            end
            default: begin
                cap_state_next = cap_done;
            end
        endcase
    end

    // Registers only.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg <= CFG_RESET;
            cap_state_reg <= cap_wait;
        end else begin
            cfg_reg <= cfg_next;
            cap_state_reg <= cap_state_next;
        end
    end

    assign chip_config_reg_o = cfg_reg;

    // ==========================================================
    // Mode decode.
    // ==========================================================
    bus_width_t width_mode;

    // Strap high forces big-endian; otherwise software's pointer bit decides. The
    // pointer bit cannot turn a strapped big-endian part back to little-endian.
    always_comb begin
        big_endian_o = cfg_reg[CFG_BIG_END_BIT] | rx_pointer_big_end_i;
    end

    // The package option outranks the latched width bits, which stay clear then.
    always_comb begin
        if (bus32_option_i) begin
            width_mode = width_32;
        end else if (cfg_reg[CFG_BUS16_BIT]) begin
            width_mode = width_16;
        end else begin
            width_mode = width_8;
        end
        case (width_mode)
            width_8: bus_width_o = 2'h0;
            width_16: bus_width_o = 2'h1;
            width_32: bus_width_o = 2'h2;
            default: bus_width_o = 2'h0;
        endcase
    end

    // ==========================================================
    // Byte-lane data path.
    // ==========================================================
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] wdata_next;
    logic [LANES-1:0] we_reg;
    logic [LANES-1:0] we_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [LANES-1:0] drive_reg;
    logic [LANES-1:0] drive_next;

    // Write lanes: only lanes whose enable is low take the pin byte. Write wins
    // over read, so a host that raises both never sees the bus driven against it.
    always_comb begin
        wdata_next = wdata_reg;
        we_next = LANES_OFF;
        for (int i = 0; i < LANES; i++) begin
            if (!req_i.lane_enable_n[i] && req_i.write) begin
                wdata_next[i*LANE_W +: LANE_W] = data_in_i[i*LANE_W +: LANE_W];
                we_next[i] = 1'b1;
            end
        end
    end

    // Registers only.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdata_reg <= DATA_ZERO;
            we_reg <= LANES_OFF;
        end else begin
            wdata_reg <= wdata_next;
            we_reg <= we_next;
        end
    end

    // Read lanes: enabled lanes load the core byte and drive the pins for one
    // cycle; disabled lanes keep their old byte and stay released.
    always_comb begin
        rdata_next = rdata_reg;
        drive_next = LANES_OFF;
        for (int i = 0; i < LANES; i++) begin
            if (!req_i.lane_enable_n[i] && req_i.read && !req_i.write) begin
                rdata_next[i*LANE_W +: LANE_W] = core_rdata_i[i*LANE_W +: LANE_W];
                drive_next[i] = 1'b1;
            end
        end
    end

    // Registers only.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= DATA_ZERO;
            drive_reg <= LANES_OFF;
        end else begin
            rdata_reg <= rdata_next;
            drive_reg <= drive_next;
        end
    end

    // Enable is low while driving, per lane.
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            data_oe_n_o[i*LANE_W +: LANE_W] = {LANE_W{~drive_reg[i]}};
        end
    end

    assign data_out_o = rdata_reg;
    assign core_wdata_o = wdata_reg;
    assign core_lane_we_o = we_reg;

endmodule : host_lane_strap

`default_nettype wire

/* File: lane_cfg_pkg.sv */
package lane_cfg_pkg;

    // ==========================================================
    // Widths, field positions and reset values.
    // ==========================================================
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int CFG_W = 16;
    localparam int CFG_BUS8_BIT = 6;
    localparam int CFG_BUS16_BIT = 7;
    localparam int CFG_BIG_END_BIT = 10;
    localparam int RXP_BIG_END_BIT = 11;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [LANES-1:0] LANES_OFF = 4'h0;
    localparam logic [1:0] SYNC_ZERO = 2'h0;
    localparam logic [1:0] SYNC_ONES = 2'h3;

    // Bus width the straps select; 32-bit is a property of the package option.
    typedef enum {
        width_8,
        width_16,
        width_32
    } bus_width_t;

    // Strap pin levels, taken together.
    typedef struct packed {
        logic endian_select_strap;
        logic bus_width_strap;
        logic eeprom_present_strap;
    } strap_t;

    // Host-side bus request seen by the lane logic.
    typedef struct packed {
        logic [LANES-1:0] lane_enable_n;
        logic read;
        logic write;
        logic [DATA_W-1:0] wdata;
    } host_req_t;

endpackage : lane_cfg_pkg

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Three-stage synchroniser; a change is accepted once stages two and three agree.
// ==========================================================
module pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);
    import lane_cfg_pkg::*;

    logic [1:0] stage_reg;
    logic [1:0] stage_next;
    logic third_reg;
    logic third_next;
    logic level_reg;
    logic level_next;

    // Shift chain; the first stage feeds only the second.
    always_comb begin
        stage_next = {stage_reg[0], pin_i};
        third_next = stage_reg[1];
        level_next = (stage_reg[1] == third_reg) ? third_reg : level_reg;
    end

    // The chain runs through reset on purpose. Straps are only valid while reset is
    // held, so their levels must already be in the chain when reset ends.
    always_ff @(posedge clk_i) begin
        stage_reg <= stage_next;
        third_reg <= third_next;
    end

    // Only the accepted level is cleared by reset.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;

endmodule : pin_sync

`default_nettype wire

/* File: hls_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks of the lane and strap block.
module hls_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bus32_option_i,
    input wire lane_cfg_pkg::strap_t strap_i,
    input wire lane_cfg_pkg::host_req_t req_i,
    input wire logic [31:0] data_in_i,
    input wire logic [31:0] core_rdata_i,
    input wire logic rx_pointer_big_end_i,
    input wire logic [31:0] data_out_o,
    input wire logic [31:0] data_oe_n_o,
    input wire logic [31:0] core_wdata_o,
    input wire logic [3:0] core_lane_we_o,
    input wire logic [15:0] chip_config_reg_o,
    input wire logic big_endian_o,
    input wire logic [1:0] bus_width_o
);
    import lane_cfg_pkg::*;
    logic [3:0] cnt_reg;
    logic [3:0] wr;
    logic [3:0] rd;
    // Edges since release; it saturates so the freeze check runs for ever.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'h9) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    strap_t strap_seen_reg;
    // Strap levels as they stood while reset was held; the capture must match these.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_seen_reg <= strap_i;
        end
    end
    // Write wins over read on a lane.
    assign wr = {4{req_i.write}} & ~req_i.lane_enable_n;
    assign rd = {4{req_i.read & ~req_i.write}} & ~req_i.lane_enable_n;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_settled;
        cnt_reg == 4'h3;
    endsequence
    a_lane_strobe: assert property (core_lane_we_o == $past(wr))
        else $error("lane strobe wrong");
    a_strap_capture: assert property (s_settled |->
        chip_config_reg_o[10] == strap_seen_reg.endian_select_strap
        && chip_config_reg_o[7:6] == ((bus32_option_i | strap_seen_reg.eeprom_present_strap)
        ? 2'h0 : {strap_seen_reg.bus_width_strap, !strap_seen_reg.bus_width_strap}))
        else $error("strap capture wrong");
    a_cfg_frozen: assert property (cnt_reg >= 4'h3 |-> $stable(chip_config_reg_o))
        else $error("config moved");
    a_endian_merge: assert property (
        big_endian_o == (chip_config_reg_o[10] | rx_pointer_big_end_i))
        else $error("byte order wrong");
    a_width_decode: assert property (
        bus_width_o == (bus32_option_i ? 2'h2 : {1'b0, chip_config_reg_o[7]}))
        else $error("bus width wrong");
    for (genvar i = 0; i < 4; i++) begin : g_lane
        a_lane_wdata: assert property (wr[i] |=>
            core_wdata_o[8*i+:8] == $past(data_in_i[8*i+:8]))
            else $error("write data wrong");
        a_read_drive: assert property (data_oe_n_o[8*i+:8] == {8{!$past(rd[i])}})
            else $error("drive enable wrong");
        a_read_data: assert property (rd[i] |=>
            data_out_o[8*i+:8] == $past(core_rdata_i[8*i+:8]))
            else $error("read data wrong");
    end
endmodule : hls_properties
bind host_lane_strap hls_properties u_hls_properties (.*);
`default_nettype wire

/* File: host_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host side: issues requests and resolves the shared data pins.
module host_cpu_model (
    input wire logic [31:0] dev_data_i,
    input wire logic [31:0] dev_oe_n_i,
    output var lane_cfg_pkg::host_req_t req_o,
    output logic [31:0] bus_o
);
    import lane_cfg_pkg::*;
    logic [31:0] hd = 32'h0000_0000;
    initial req_o = {4'hF, 34'h0_0000_0000};
    // Device wins where it drives, the host drives on writes, released pins pull down.
    assign bus_o = (dev_data_i & ~dev_oe_n_i) | (hd & dev_oe_n_i & {32{req_o.write}});
    // Called just after an edge; a request stands until the next call, one cycle when calls come back to back.
    task automatic access(input logic [5:0] rq, input logic [31:0] d);
        req_o <= {rq, 32'h0000_0000};
        hd <= d;
    endtask : access
endmodule : host_cpu_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Self-checking bench for the lane and strap block.
module testbench;
    import lane_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic b32 = 1'b0;
    logic rxp = 1'b0;
    strap_t st = 3'h0;
    logic [31:0] rdat = 32'h0000_0000;
    logic [31:0] d = 32'h0000_0000;
    logic [31:0] dp;
    logic [31:0] ew = 32'h0000_0000;
    logic [31:0] bus, dout, oen, wdat;
    logic [3:0] we;
    logic [15:0] cfg;
    logic be;
    logic [1:0] bw;
    host_req_t rq;
    int err_count = 0;
    int compares = 0;
    // Rows: lane enables, read, write; then strobes and drive enables expected.
    logic [13:0] rows [8] = '{14'h391F, 14'h0DCF, 14'h03FF, 14'h1605,
        14'h3C0F, 14'h3D0F, 14'h2A0A, 14'h000F};
    // Cases: straps, 32-bit option, config expected, width code expected.
    logic [21:0] cases [5] = '{22'h30_1201, 22'h00_0100, 22'h14_0002, 22'h18_0000, 22'h24_1002};
    host_lane_strap u_host_lane_strap (.clk_i(clk_i), .rst_i(rst_i), .bus32_option_i(b32),
        .strap_i(st), .req_i(rq), .data_in_i(bus), .core_rdata_i(rdat),
        .rx_pointer_big_end_i(rxp), .data_out_o(dout), .data_oe_n_o(oen), .core_wdata_o(wdat),
        .core_lane_we_o(we), .chip_config_reg_o(cfg), .big_endian_o(be), .bus_width_o(bw));
    host_cpu_model u_host_cpu_model (.dev_data_i(dout), .dev_oe_n_i(oen), .req_o(rq), .bus_o(bus));
    always #50 clk_i = ~clk_i;
    function automatic logic [31:0] x8(input logic [3:0] l);
        return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction : x8
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_of_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // Straps stay put through reset and well past the capture point.
    task automatic do_reset(input logic [2:0] s, input logic b);
        @(posedge clk_i);
        st <= s;
        b32 <= b;
        rxp <= 1'b0;
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
    endtask : do_reset
    // Rows go back to back: row k is driven at one edge and checked after the next.
    initial begin
        do_reset(3'h6, 1'b0);
        for (int k = 0; k <= 8; k++) begin
            @(posedge clk_i);
            dp = d;
            d = 32'(32'h0101_0101 * (k + 1));
            u_host_cpu_model.access(k < 8 ? rows[k][13:8] : 6'h3C, d);
            rdat <= ~d;
            if (k > 0) begin
                #1;
                ew = (ew & ~x8(rows[k-1][7:4])) | (dp & x8(rows[k-1][7:4]));
                chk("strobe", 32'(rows[k-1][7:4]), 32'(we));
                chk("wdata", ew, wdat);
                chk("drive", x8(rows[k-1][3:0]), oen);
                chk("rdata", ~dp | x8(rows[k-1][3:0]), dout | x8(rows[k-1][3:0]));
            end
        end
        // Each strap case, then a strap swing that must not reach the config.
        foreach (cases[j]) begin
            do_reset(cases[j][21:19], cases[j][18]);
            chk("config", 32'(cases[j][17:2]), 32'(cfg));
            chk("width", 32'(cases[j][1:0]), 32'(bw));
            chk("endian", 32'(cases[j][21]), 32'(be));
            @(posedge clk_i);
            rxp <= 1'b1;
            st <= ~cases[j][21:19];
            repeat (6) @(posedge clk_i);
            #1;
            chk("endian", 32'h0000_0001, 32'(be));
            chk("config", 32'(cases[j][17:2]), 32'(cfg));
        end
        // Straps that flip the moment reset drops must not be seen.
        @(posedge clk_i);
        st <= 3'h4;
        b32 <= 1'b0;
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        st <= 3'h2;
        repeat (12) @(posedge clk_i);
        #1;
        chk("config", 32'h0000_0440, 32'(cfg));
        chk("width", 32'h0000_0000, 32'(bw));
        end_of_test();
    end
    // Watchdog well beyond the few hundred cycles the run needs.
    initial begin
        repeat (2000) @(posedge clk_i);
        err_count++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
